// ===== rtl/conv_ctrl_pkg.sv
// Register map, field layout and codes of the converter control block.
// Assumes a 32-bit AHB-Lite register bus clocked by hclk.
package conv_ctrl_pkg;

	// ----------------------------------------------------------------
	// Register offsets
	// ----------------------------------------------------------------
	localparam logic [11:0] slots_offset = 12'h034;
	localparam logic [11:0] result_offset = 12'h04C;
	localparam logic [11:0] oversample_offset = 12'h080;
	localparam logic [11:0] length_offset = 12'h0C0;

	// ----------------------------------------------------------------
	// Field layout and reset values
	// ----------------------------------------------------------------
	localparam int slot_width = 5;
	localparam int slot_count = 6;
	localparam logic [4:0] max_channel = 5'h11;
	localparam logic [31:0] slots_mask = 32'h3FFFFFFF;
	localparam logic [31:0] oversample_mask = 32'h000033FD;
	localparam logic [31:0] slots_reset = 32'h00000000;
	localparam logic [31:0] result_reset = 32'h00000000;
	localparam logic [31:0] oversample_reset = 32'h00000000;
	localparam int resolution_lsb = 12;
	localparam int trigger_mode_bit = 9;
	localparam int shift_lsb = 5;
	localparam int ratio_lsb = 2;
	localparam int enable_bit = 0;
	localparam logic [3:0] max_shift = 4'h8;

	// ----------------------------------------------------------------
	// Sequencer states
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {
		st_idle = 2'b00,
		st_wait_trigger = 2'b01,
		st_convert = 2'b10
	} seq_state_t;

endpackage : conv_ctrl_pkg

// ===== rtl/sample_accumulator.sv
// Oversampling accumulator: sums samples, shifts the sum on the last one.
// Assumes the sequencer presents one sample per pulse of sample_valid.
`timescale 1ns/1ps
module sample_accumulator (
	// Clock and reset
	input wire logic hclk,
	input wire logic hresetn,
	// Control
	input wire logic clear,
	input wire logic sample_valid,
	input wire logic [15:0] sample,
	input wire logic [3:0] shift,
	// Result
	output logic [15:0] shifted
);

	logic [23:0] sum_reg;

	// Largest sum is 256 samples of 16 bits; 24 bits hold it even for
	// full-scale 16-bit inputs, and converter data is at most 12 bits wide.
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			sum_reg <= 24'h000000;
		else if (clear)
			sum_reg <= 24'h000000;
		else if (sample_valid)
			sum_reg <= sum_reg + {8'h00, sample};
	end

	logic [23:0] total;
	assign total = sum_reg + {8'h00, sample};
	// Reserved shift codes are clamped to the largest legal shift
	always_comb
	begin
		if (shift > conv_ctrl_pkg::max_shift)
			shifted = total[23:8];
		else
			shifted = 16'((total >> shift));
	end

endmodule : sample_accumulator

// ===== rtl/conv_ctrl.sv
// Converter register and sequence control behind an AHB-Lite slave.
// Assumes the analog core answers each start with one conv_done pulse.
//
// Function
// - Each five-bit slot selects channel 0..17 converted at that sequence position.
// - Slots zero to five packed from bit 0; bits 31:30 reserved.
// - Conversions per sequence equal the length field plus one, in slot order.
// - Result low half shows latest conversion; writes to result have no effect.
// - In synchronised mode the result upper half holds the partner's result.
// - Resolution field bits 13:12 selects 12, 10, 8 or 6 bits.
// - Trigger mode clear: all oversampled conversions run after one trigger.
// - Trigger mode set: each oversampled conversion waits for its own trigger; here the first conversion of each later position starts without one.
// - Shift field bits 8:5 shifts the sum right zero to eight bits.
// - Ratio field bits 4:2 selects 2x up to 256x samples.
// - Bit 0 enables the oversampler.
//
// Chosen here: the AHB-Lite slave port.
`timescale 1ns/1ps
module conv_ctrl (
	// AHB-Lite slave
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [11:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	// Converter core
	input wire logic converter_on,
	input wire logic sync_mode,
	input wire logic trigger,
	input wire logic conv_done,
	input wire logic [15:0] conv_data,
	input wire logic [15:0] partner_converter_result,
	output logic conv_start,
	output logic [4:0] conv_channel,
	output logic [1:0] conversion_resolution
);

	// ----------------------------------------------------------------
	// Bus slave
	// ----------------------------------------------------------------
	logic wr_pending_reg;
	logic [11:0] addr_reg;
	logic [31:0] slots_reg;
	logic [31:0] oversample_reg;
	logic [3:0] sequence_length_minus_one;
	logic [31:0] result_reg;
	logic [15:0] result_low_reg;
	logic [15:0] result_high_reg;

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			wr_pending_reg <= 1'b0;
			addr_reg <= 12'h000;
		end
		else if (hready)
		begin
			wr_pending_reg <= hsel && htrans[1] && hwrite;
			addr_reg <= haddr;
		end
	end

	// Register reads come from a flop loaded in the address phase: zero wait states
	assign hreadyout = 1'b1;
	assign hresp = 1'b0;

	logic rd_now;
	logic [31:0] rd_data_reg;
	assign rd_now = hready && hsel && htrans[1] && !hwrite;

	// Sampled in the address phase so hrdata comes from a flop
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			rd_data_reg <= 32'h00000000;
		else if (rd_now)
		begin
			unique case (haddr)
				conv_ctrl_pkg::slots_offset: rd_data_reg <= slots_reg;
				conv_ctrl_pkg::result_offset: rd_data_reg <= result_reg;
				conv_ctrl_pkg::oversample_offset: rd_data_reg <= oversample_reg;
				conv_ctrl_pkg::length_offset: rd_data_reg <= {28'h0000000, sequence_length_minus_one};
				default: rd_data_reg <= 32'h00000000;
			endcase
		end
	end
	assign hrdata = rd_data_reg;

	// Word writes only are supported; a narrower size still writes the word
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			slots_reg <= conv_ctrl_pkg::slots_reset;
		else if (wr_pending_reg && addr_reg == conv_ctrl_pkg::slots_offset)
			slots_reg <= hwdata & conv_ctrl_pkg::slots_mask;
	end

	// Held while converter is on so a live sequence keeps its setup
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			oversample_reg <= conv_ctrl_pkg::oversample_reset;
		else if (wr_pending_reg && addr_reg == conv_ctrl_pkg::oversample_offset && !converter_on)
			oversample_reg <= hwdata & conv_ctrl_pkg::oversample_mask;
	end

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			sequence_length_minus_one <= 4'h0;
		else if (wr_pending_reg && addr_reg == conv_ctrl_pkg::length_offset)
			sequence_length_minus_one <= hwdata[3:0];
	end

	// ----------------------------------------------------------------
	// Field decode
	// ----------------------------------------------------------------
	logic per_sample_trigger_mode;
	logic [3:0] accumulate_shift;
	logic [2:0] accumulate_ratio;
	logic accumulator_enable;
	assign conversion_resolution = oversample_reg[conv_ctrl_pkg::resolution_lsb +: 2];
	assign per_sample_trigger_mode = oversample_reg[conv_ctrl_pkg::trigger_mode_bit];
	assign accumulate_shift = oversample_reg[conv_ctrl_pkg::shift_lsb +: 4];
	assign accumulate_ratio = oversample_reg[conv_ctrl_pkg::ratio_lsb +: 3];
	assign accumulator_enable = oversample_reg[conv_ctrl_pkg::enable_bit];

	function automatic logic [4:0] slot_channel(input logic [31:0] slots, input logic [2:0] idx);
		logic [4:0] ch;
		ch = slots[idx * conv_ctrl_pkg::slot_width +: conv_ctrl_pkg::slot_width];
		// Out-of-range channel numbers fall back to channel zero
		slot_channel = (ch > conv_ctrl_pkg::max_channel) ? 5'h00 : ch;
	endfunction : slot_channel

	// ----------------------------------------------------------------
	// Sequencer
	// ----------------------------------------------------------------
	conv_ctrl_pkg::seq_state_t state_reg;
	logic [3:0] position_reg;
	logic [8:0] sample_count_reg;
	logic [8:0] ratio_count;
	logic last_sample;
	logic last_position;
	assign ratio_count = 9'(9'h002 << accumulate_ratio);
	assign last_sample = !accumulator_enable || (sample_count_reg == ratio_count - 9'h001);
	assign last_position = position_reg == sequence_length_minus_one;

	// Positions past slot five wrap within the six slots held here
	assign conv_channel = slot_channel(slots_reg, 3'(position_reg % 4'(conv_ctrl_pkg::slot_count)));
	assign conv_start = (state_reg == conv_ctrl_pkg::st_idle && converter_on && trigger)
		|| (state_reg == conv_ctrl_pkg::st_wait_trigger && trigger);

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			state_reg <= conv_ctrl_pkg::st_idle;
			position_reg <= 4'h0;
			sample_count_reg <= 9'h000;
		end
		else if (!converter_on)
		begin
			state_reg <= conv_ctrl_pkg::st_idle;
			position_reg <= 4'h0;
			sample_count_reg <= 9'h000;
		end
		else
		begin
			unique case (state_reg)
				conv_ctrl_pkg::st_idle, conv_ctrl_pkg::st_wait_trigger:
					if (trigger)
						state_reg <= conv_ctrl_pkg::st_convert;
				conv_ctrl_pkg::st_convert:
					if (conv_done)
					begin
						if (!last_sample)
						begin
							sample_count_reg <= sample_count_reg + 9'h001;
							// Per-sample triggering waits; otherwise run back to back
							if (per_sample_trigger_mode)
								state_reg <= conv_ctrl_pkg::st_wait_trigger;
							else
								state_reg <= conv_ctrl_pkg::st_convert;
						end
						else
						begin
							sample_count_reg <= 9'h000;
							position_reg <= last_position ? 4'h0 : position_reg + 4'h1;
							state_reg <= last_position ? conv_ctrl_pkg::st_idle : conv_ctrl_pkg::st_convert;
						end
					end
				default: state_reg <= conv_ctrl_pkg::st_idle;
			endcase
		end
	end

	// ----------------------------------------------------------------
	// Result path
	// ----------------------------------------------------------------
	logic [15:0] accumulated;
	logic sample_in;
	assign sample_in = state_reg == conv_ctrl_pkg::st_convert && conv_done;

	// Cleared when the converter stops, so a cut run leaves no partial sum
	sample_accumulator accumulator (
		.hclk(hclk),
		.hresetn(hresetn),
		.clear((sample_in && last_sample) || !converter_on),
		.sample_valid(sample_in && accumulator_enable),
		.sample(conv_data),
		.shift(accumulate_shift),
		.shifted(accumulated)
	);

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			result_low_reg <= conv_ctrl_pkg::result_reset[15:0];
		else if (sample_in && last_sample)
			result_low_reg <= accumulator_enable ? accumulated : conv_data;
	end

	// Partner result follows the converter only in synchronised mode
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			result_high_reg <= conv_ctrl_pkg::result_reset[31:16];
		else if (sync_mode && sample_in && last_sample)
			result_high_reg <= partner_converter_result;
	end

	// Bus writes never reach these flops
	assign result_reg = {result_high_reg, result_low_reg};

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	a_result_readonly: assert property (@(posedge hclk) disable iff (!hresetn)
		(wr_pending_reg && addr_reg == conv_ctrl_pkg::result_offset && !sample_in) |=> $stable(result_reg))
		else $error("result changed by write");
	a_oversample_locked: assert property (@(posedge hclk) disable iff (!hresetn)
		converter_on |=> $stable(oversample_reg) || !$past(converter_on))
		else $error("oversample setup changed while on");
	a_slots_reserved: assert property (@(posedge hclk) disable iff (!hresetn)
		slots_reg[31:30] == 2'b00)
		else $error("reserved slot bits set");
	a_channel_range: assert property (@(posedge hclk) disable iff (!hresetn)
		conv_channel <= conv_ctrl_pkg::max_channel)
		else $error("channel out of range");
	a_trigger_wait: assert property (@(posedge hclk) disable iff (!hresetn)
		(state_reg == conv_ctrl_pkg::st_wait_trigger && !trigger) |=> state_reg != conv_ctrl_pkg::st_convert)
		else $error("conversion without trigger");
	a_back_to_back: assert property (@(posedge hclk) disable iff (!hresetn)
		(sample_in && !last_sample && !per_sample_trigger_mode && converter_on) |=> state_reg == conv_ctrl_pkg::st_convert)
		else $error("back to back run stalled");
	a_sequence_end: assert property (@(posedge hclk) disable iff (!hresetn)
		(sample_in && last_sample && last_position && converter_on) |=> position_reg == 4'h0)
		else $error("sequence did not wrap");
	a_plain_result: assert property (@(posedge hclk) disable iff (!hresetn)
		(sample_in && !accumulator_enable) |=> result_reg[15:0] == $past(conv_data))
		else $error("result not latest conversion");
	a_ratio_count: assert property (@(posedge hclk) disable iff (!hresetn)
		sample_count_reg < ratio_count)
		else $error("sample count beyond ratio");
	a_partner_half: assert property (@(posedge hclk) disable iff (!hresetn)
		(sample_in && last_sample && sync_mode) |=> result_reg[31:16] == $past(partner_converter_result))
		else $error("partner result missing");
	a_hold_until_last: assert property (@(posedge hclk) disable iff (!hresetn)
		(sample_in && !last_sample) |=> $stable(result_low_reg))
		else $error("result written before last sample");
	a_count_restart: assert property (@(posedge hclk) disable iff (!hresetn)
		(sample_in && last_sample) |=> sample_count_reg == 9'h000)
		else $error("sample count not restarted");
	a_wait_after_sample: assert property (@(posedge hclk) disable iff (!hresetn)
		(sample_in && !last_sample && per_sample_trigger_mode && converter_on) |=> state_reg == conv_ctrl_pkg::st_wait_trigger)
		else $error("no wait for next trigger");
	a_start_on_trigger: assert property (@(posedge hclk) disable iff (!hresetn)
		(state_reg == conv_ctrl_pkg::st_idle && converter_on && trigger) |=> state_reg == conv_ctrl_pkg::st_convert)
		else $error("trigger did not start conversion");
	a_idle_when_off: assert property (@(posedge hclk) disable iff (!hresetn)
		!converter_on |=> (state_reg == conv_ctrl_pkg::st_idle && position_reg == 4'h0))
		else $error("sequencer ran while off");
	a_upper_unsynced: assert property (@(posedge hclk) disable iff (!hresetn)
		!sync_mode |=> $stable(result_high_reg))
		else $error("partner half changed outside sync mode");

	c_sequence_done: cover property (@(posedge hclk) disable iff (!hresetn)
		sample_in && last_sample && last_position);
	c_triggered_wait: cover property (@(posedge hclk) disable iff (!hresetn)
		state_reg == conv_ctrl_pkg::st_wait_trigger ##1 state_reg == conv_ctrl_pkg::st_convert);
	c_oversampled: cover property (@(posedge hclk) disable iff (!hresetn)
		sample_in && last_sample && accumulator_enable);
	c_result_read: cover property (@(posedge hclk) disable iff (!hresetn)
		rd_now && haddr == conv_ctrl_pkg::result_offset);
	c_cut_run: cover property (@(posedge hclk) disable iff (!hresetn)
		state_reg == conv_ctrl_pkg::st_convert && !converter_on);

endmodule : conv_ctrl

// ===== test/adc_sequence_result_oversample_test.sv
// Self-checking bench for the converter control block.
// Assumes conv_ctrl alone on the bus, its hreadyout fed back as hready.
`timescale 1ns/1ps
`define CHK(nm, e, g) begin check_count++; if ((g) !== (e)) begin miscompares++; \
	$display("ERROR %s expected %h seen %h", nm, e, g); end end
module adc_sequence_result_oversample_test;
	logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0, converter_on = 1'b0;
	logic sync_mode = 1'b0, trigger = 1'b0, conv_done = 1'b0;
	logic [11:0] haddr = 12'h000;
	logic [1:0] htrans = 2'b00;
	logic [2:0] hsize = 3'b010;
	logic [31:0] hwdata = 32'h00000000;
	logic [15:0] conv_data = 16'h0000, partner_converter_result = 16'h0000;
	wire logic [31:0] hrdata;
	wire logic hreadyout, hresp, conv_start;
	wire logic [4:0] conv_channel;
	wire logic [1:0] conversion_resolution;
	int miscompares = 0;
	int check_count = 0;
	logic [31:0] rd, w, prev;
	logic [4:0] slot [6];
	logic [2:0] ra_t [5] = '{3'h0, 3'h0, 3'h2, 3'h7, 3'h1};
	logic [3:0] sh_t [5] = '{4'h0, 4'h8, 4'h3, 4'h8, 4'h5};
	logic tv_t [5] = '{1'b0, 1'b1, 1'b0, 1'b0, 1'b1};

	conv_ctrl DUT (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
		.hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
		.converter_on(converter_on), .sync_mode(sync_mode), .trigger(trigger), .conv_done(conv_done),
		.conv_data(conv_data), .partner_converter_result(partner_converter_result), .conv_start(conv_start),
		.conv_channel(conv_channel), .conversion_resolution(conversion_resolution));

	// ------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------
	task automatic conclude;
		if (miscompares == 0 && check_count > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : conclude

	task automatic wait_ready;
		int n;
		n = 0;
		@(posedge hclk);
		while (hreadyout !== 1'b1 && n < 100)
		begin
			n++;
			@(posedge hclk);
		end
		if (n == 100)
			miscompares++;
	endtask : wait_ready

	// Called just after a rising edge; read data taken at the data phase edge
	task automatic bus(input logic [11:0] a, input logic wr, input logic [31:0] d);
		hsel <= 1'b1;
		haddr <= a;
		hwrite <= wr;
		htrans <= 2'b10;
		wait_ready();
		htrans <= 2'b00;
		hwdata <= d;
		wait_ready();
		rd = hrdata;
		`CHK("hresp", 1'b0, hresp)
	endtask : bus

	task automatic expect_reg(input string nm, input logic [11:0] a, input logic [31:0] e);
		bus(a, 1'b0, 32'h00000000);
		`CHK(nm, e, rd)
	endtask : expect_reg

	task automatic fire;
		trigger <= 1'b1;
		@(negedge hclk);
		`CHK("conv_start", 1'b1, conv_start)
		@(posedge hclk);
		trigger <= 1'b0;
		@(posedge hclk);
	endtask : fire

	task automatic sample_in(input logic [15:0] d);
		conv_done <= 1'b1;
		conv_data <= d;
		@(posedge hclk);
		conv_done <= 1'b0;
		conv_data <= ~d;
		@(posedge hclk);
	endtask : sample_in

	function automatic logic [31:0] ovs_word(input logic [1:0] res, input logic tv, input logic [3:0] sh,
		input logic [2:0] ra, input logic en);
		return {18'h00000, res, 2'b00, tv, sh, ra, 1'b0, en};
	endfunction : ovs_word

	function automatic logic [15:0] shifted(input logic [23:0] sum, input logic [3:0] sh);
		return 16'(sum >> sh);
	endfunction : shifted

	// ------------------------------------------------------------
	// Clock, watchdog and tests
	// ------------------------------------------------------------
	initial
	begin
		forever #12.5 hclk = ~hclk;
	end

	initial
	begin
		#(25 * 40000);
		miscompares++;
		conclude();
	end

	initial
	begin
		logic [23:0] sum;
		logic [15:0] d, part;
		void'($urandom(32'h323F4AE9));
		repeat (5) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		expect_reg("slots", conv_ctrl_pkg::slots_offset, 32'h00000000);
		expect_reg("result", conv_ctrl_pkg::result_offset, 32'h00000000);
		expect_reg("oversample", conv_ctrl_pkg::oversample_offset, 32'h00000000);
		expect_reg("unmapped", 12'h010, 32'h00000000);
		// Reserved top bits set on purpose, channel 0 and 17 as corners
		w = 32'hC0000000;
		for (int i = 0; i < 6; i++)
		begin
			slot[i] = (i == 5) ? 5'h11 : (i == 0) ? 5'h00 : 5'($urandom_range(17));
			w[5 * i +: 5] = slot[i];
		end
		bus(conv_ctrl_pkg::slots_offset, 1'b1, w);
		expect_reg("slots", conv_ctrl_pkg::slots_offset, w & 32'h3FFFFFFF);
		bus(conv_ctrl_pkg::length_offset, 1'b1, 32'h00000005);
		// Accumulator off with a large ratio: every sample must land alone
		w = ovs_word(2'($urandom), 1'b0, 4'h3, 3'h7, 1'b0);
		bus(conv_ctrl_pkg::oversample_offset, 1'b1, w);
		expect_reg("oversample", conv_ctrl_pkg::oversample_offset, w);
		`CHK("resolution", w[13:12], conversion_resolution)
		converter_on <= 1'b1;
		fire();
		for (int i = 0; i < 6; i++)
		begin
			@(negedge hclk);
			`CHK("channel", slot[i], conv_channel)
			@(posedge hclk);
			d = 16'($urandom);
			sample_in(d);
			expect_reg("result", conv_ctrl_pkg::result_offset, {16'h0000, d});
		end
		prev = {16'h0000, d};
		bus(conv_ctrl_pkg::result_offset, 1'b1, $urandom);
		expect_reg("result", conv_ctrl_pkg::result_offset, prev);
		bus(conv_ctrl_pkg::oversample_offset, 1'b1, ovs_word(2'b11, 1'b1, 4'h8, 3'h5, 1'b1));
		expect_reg("oversample", conv_ctrl_pkg::oversample_offset, w);
		sync_mode <= 1'b1;
		bus(conv_ctrl_pkg::length_offset, 1'b1, 32'h00000000);
		for (int c = 0; c < 5; c++)
		begin
			converter_on <= 1'b0;
			w = ovs_word(2'($urandom), tv_t[c], sh_t[c], ra_t[c], 1'b1);
			bus(conv_ctrl_pkg::oversample_offset, 1'b1, w);
			expect_reg("oversample", conv_ctrl_pkg::oversample_offset, w);
			`CHK("resolution", w[13:12], conversion_resolution)
			converter_on <= 1'b1;
			part = 16'($urandom);
			partner_converter_result <= part;
			sum = 24'h000000;
			fire();
			// Cut a run after one sample: the next run must start from an empty sum
			if (c == 0)
			begin
				sample_in(16'h0FFF);
				converter_on <= 1'b0;
				@(posedge hclk);
				converter_on <= 1'b1;
				fire();
			end
			for (int k = 0; k < (2 << ra_t[c]); k++)
			begin
				if (tv_t[c] && k > 0)
					fire();
				if (k == (2 << ra_t[c]) - 1)
					expect_reg("held", conv_ctrl_pkg::result_offset, prev);
				d = 16'($urandom_range(4095));
				sum += d;
				sample_in(d);
			end
			prev = {part, shifted(sum, sh_t[c])};
			expect_reg("result", conv_ctrl_pkg::result_offset, prev);
		end
		conclude();
	end
endmodule : adc_sequence_result_oversample_test
